// File: src/handoff_consts.vh
/*
  Constants for the passive handoff port controller: timer defaults,
  limits, tick rate and status field positions.
  Assumes a single 100 MHz system clock.
*/
`ifndef HANDOFF_CONSTS_VH
`define HANDOFF_CONSTS_VH

// Clock rate in Hz and one-second tick length in cycles
`define CLK_HZ          100000000
`define TICK_CYCLES     (`CLK_HZ)

// Timer defaults and limits in seconds
`define TP1_DEF_S       10'h002
`define TP2_DEF_S       10'h002
`define TP3_DEF_S       10'h03c
`define TP4_DEF_S       10'h03c
`define TP5_DEF_S       10'h002
`define TP_MIN_S        10'h001
`define TP_MAX_S        10'h3e7

// Register offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_TP12        4'h8
`define REG_TP34        4'hc

// Control fields
`define CTRL_MANUAL     0
`define CTRL_ERRCLR     1

// Status fields
`define ST_ERR_LO       0
`define ST_STATE_LO     8

// Number of handshake timers
`define NUM_TP          5

`endif

// File: src/handoff_port.v
/*
  Passive-side handoff port controller with Avalon-MM register slave.
  Sequences load and unload handshakes against the carrier sensors,
  runs five second-resolution handshake timers, follows access mode and
  emergency stop. Link and sensor pins come from outside and are
  synchronised by two flip-flops; the bus is on ref_clk.
*/
// Local design decisions: the Avalon-MM register port and the register offsets.
`include "handoff_consts.vh"
`default_nettype none

module handoff_port #(
  parameter TICK_LEN = `TICK_CYCLES   // Cycles per one-second tick
) (
  input  wire        ref_clk,         // System clock
  input  wire        nrst,            // Asynchronous reset, active low
  // Avalon-MM slave
  input  wire [3:0]  address,         // Byte address
  input  wire        read,            // Read strobe
  input  wire        write,           // Write strobe
  input  wire [31:0] writedata,       // Write data
  input  wire [3:0]  byteenable,      // Byte lanes
  output reg  [31:0] readdata,        // Read data
  output reg         waitrequest,     // Stall until answer ready
  // Link from active vehicle
  input  wire        cs_0,            // Carrier stage select 0
  input  wire        cs_1,            // Carrier stage select 1
  input  wire        valid,           // Handoff valid
  input  wire        tr_req,          // Transfer request
  input  wire        busy,            // Transfer in progress
  input  wire        compt,           // Transfer complete
  // Link to active vehicle
  output reg         ho_avbl,         // Handoff available
  output reg         l_req,           // Load request
  output reg         u_req,           // Unload request
  output reg         ready,           // Ready for transfer
  output reg         es_n,            // Emergency stop, low when stopped
  // Equipment inputs
  input  wire        placement,       // Placement sensors all active
  input  wire        presence,        // Presence sensors active
  input  wire        estop_btn,       // Emergency stop pressed
  // Status out
  output reg  [4:0]  tp_err           // Sticky timeout flags TP1..TP5
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: nothing reads the first stage but the second
  localparam NS = 9;
  wire [NS-1:0] pins_raw = {estop_btn, presence, placement, compt, busy,
                            tr_req, valid, cs_1, cs_0};
  reg  [NS-1:0] sync1_reg;            // First stage
  reg  [NS-1:0] sync2_reg;            // Second stage, safe to use

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= {NS{1'b0}};
      sync2_reg <= {NS{1'b0}};
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire s_cs0 = sync2_reg[0];
  wire s_cs1 = sync2_reg[1];
  wire s_val = sync2_reg[2];
  wire s_trq = sync2_reg[3];
  wire s_bsy = sync2_reg[4];
  wire s_cpt = sync2_reg[5];
  wire s_plc = sync2_reg[6];
  wire s_prs = sync2_reg[7];
  wire s_est = sync2_reg[8];

  // Carrier fully placed or fully gone; half states count as neither
  wire carrier_in  = s_plc && s_prs;
  wire carrier_out = !s_plc && !s_prs;

  ////////////////////////////////////////////////////////////////////
  // Sequencer states, one-hot
  localparam [7:0] ST_IDLE = 8'h01;   // Waiting for CS_0 and VALID
  localparam [7:0] ST_REQ  = 8'h02;   // Request up, awaiting TR_REQ
  localparam [7:0] ST_RDY  = 8'h04;   // Ready up, awaiting BUSY
  localparam [7:0] ST_XFER = 8'h08;   // Busy, awaiting sensors
  localparam [7:0] ST_DONE = 8'h10;   // Request down, awaiting COMPT
  localparam [7:0] ST_REL  = 8'h20;   // Ready down, awaiting release
  localparam [7:0] ST_ABRT = 8'h40;   // Aborted, awaiting release
  localparam [7:0] ST_STOP = 8'h80;   // Emergency stop

  reg  [7:0] state_reg;
  reg  [7:0] state_next;
  reg        unload_reg;              // Current handoff is an unload
  reg        unload_next;
  reg        manual_reg;              // Manual access mode
  reg [9:0]  tp_reg [0:4];            // Timer limits in seconds
  reg        errclr_reg;              // One-cycle error clear pulse

  wire released = !s_cs0 && !s_val && !s_cpt;
  wire [4:0] expired;

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always @*
  begin
    state_next  = state_reg;
    unload_next = unload_reg;
    case (state_reg)
      ST_IDLE:
        if (ho_avbl && s_cs0 && !s_cs1 && s_val)
        begin
          // Empty port loads, occupied port unloads
          if (carrier_out)
          begin
            state_next  = ST_REQ;
            unload_next = 1'b0;
          end
          else if (carrier_in)
          begin
            state_next  = ST_REQ;
            unload_next = 1'b1;
          end
        end
      ST_REQ:
        if (expired[0])
          state_next = ST_ABRT;
        else if (s_trq)
          state_next = ST_RDY;
      ST_RDY:
        if (expired[1])
          state_next = ST_ABRT;
        else if (s_bsy)
          state_next = ST_XFER;
      ST_XFER:
        if (expired[2])
          state_next = ST_ABRT;
        else if (!unload_reg && carrier_in)
          state_next = ST_DONE;
        else if (unload_reg && carrier_out)
          state_next = ST_DONE;
      ST_DONE:
        if (expired[3])
          state_next = ST_ABRT;
        else if (!s_bsy && !s_trq && s_cpt)
          state_next = ST_REL;
      ST_REL:
        if (expired[4])
          state_next = ST_ABRT;
        else if (released)
          state_next = ST_IDLE;
      ST_ABRT:
        if (released)
          state_next = ST_IDLE;
      ST_STOP:
        if (!s_est)
          state_next = ST_ABRT;
      default:
        state_next = ST_IDLE;
    endcase
    // Stop overrides any handshake step
    if (s_est)
      state_next = ST_STOP;
    // Manual mode keeps an idle port from starting a handshake; an open one runs on
    else if (manual_reg && state_next != ST_IDLE && state_reg == ST_IDLE)
      state_next = ST_IDLE;
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg  <= ST_IDLE;
      unload_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      unload_reg <= unload_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link outputs, all registered; all but es_n from the next state, es_n from the synced stop
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ho_avbl <= 1'b0;
      l_req   <= 1'b0;
      u_req   <= 1'b0;
      ready   <= 1'b0;
      es_n    <= 1'b1;
    end
    else
    begin
      // Half-placed carrier keeps the request up (ST_XFER)
      ho_avbl <= !manual_reg && !s_est &&
                 (state_next != ST_ABRT);
      l_req   <= !unload_next &&
                 (state_next == ST_REQ || state_next == ST_RDY ||
                  state_next == ST_XFER);
      u_req   <= unload_next &&
                 (state_next == ST_REQ || state_next == ST_RDY ||
                  state_next == ST_XFER);
      ready   <= (state_next == ST_RDY || state_next == ST_XFER ||
                  state_next == ST_DONE);
      es_n    <= !s_est;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // One-second tick prescaler
  reg [31:0] pre_reg;
  reg        tick_reg;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_reg  <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else if (pre_reg >= TICK_LEN - 1)
    begin
      pre_reg  <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      pre_reg  <= pre_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Five timers, each runs only in its waiting state
  wire [7:0] tp_state [0:4];
  assign tp_state[0] = ST_REQ;
  assign tp_state[1] = ST_RDY;
  assign tp_state[2] = ST_XFER;
  assign tp_state[3] = ST_DONE;
  assign tp_state[4] = ST_REL;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_TP; gi = gi + 1)
    begin : g_tp
      sec_timer #(.W(10)) u_tmr (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .restart (state_reg != tp_state[gi]),
        .run     (state_reg == tp_state[gi]),
        .tick    (tick_reg),
        .limit   (tp_reg[gi]),
        .expired (expired[gi])
      );
    end
  endgenerate

  // Sticky error flags; a new expiry wins over a clear
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tp_err <= 5'h00;
    else
      tp_err <= (errclr_reg ? 5'h00 : tp_err) | expired;
  end

  ////////////////////////////////////////////////////////////////////
  // Register slave: one wait cycle, answer on the second edge
  function [9:0] clamp_tp;            // Keep limits within 1..999
    input [15:0] v;
    begin
      if (v < {6'h00, `TP_MIN_S})
        clamp_tp = `TP_MIN_S;
      else if (v > {6'h00, `TP_MAX_S})
        clamp_tp = `TP_MAX_S;
      else
        clamp_tp = v[9:0];
    end
  endfunction

  wire req = read || write;
  reg  ack_reg;                       // Answer stage

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_reg     <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      manual_reg  <= 1'b0;
      errclr_reg  <= 1'b0;
      tp_reg[0]   <= `TP1_DEF_S;
      tp_reg[1]   <= `TP2_DEF_S;
      tp_reg[2]   <= `TP3_DEF_S;
      tp_reg[3]   <= `TP4_DEF_S;
      tp_reg[4]   <= `TP5_DEF_S;
    end
    else
    begin
      errclr_reg  <= 1'b0;
      ack_reg     <= req && !ack_reg;
      waitrequest <= !(req && !ack_reg);
      if (req && !ack_reg && read)
      begin
        case (address)
          `REG_CTRL:   readdata <= {6'h0, tp_reg[4], 15'h0, manual_reg};
          `REG_STATUS: readdata <= {16'h0, state_reg, 3'h0, tp_err};
          `REG_TP12:   readdata <= {6'h0, tp_reg[1], 6'h0, tp_reg[0]};
          `REG_TP34:   readdata <= {6'h0, tp_reg[3], 6'h0, tp_reg[2]};
          default:     readdata <= 32'h0000_0000;  // Unmapped reads zero
        endcase
      end
      // Writes land at the edge where the master sees waitrequest low
      if (ack_reg && write)
      begin
        case (address)
          `REG_CTRL:
          begin
            if (byteenable[0])
            begin
              manual_reg <= writedata[`CTRL_MANUAL];
              errclr_reg <= writedata[`CTRL_ERRCLR];
            end
            if (byteenable[2])
              tp_reg[4] <= clamp_tp({6'h0, writedata[25:16]});
          end
          `REG_TP12:
          begin
            if (byteenable[1:0] == 2'h3)
              tp_reg[0] <= clamp_tp(writedata[15:0]);
            if (byteenable[3:2] == 2'h3)
              tp_reg[1] <= clamp_tp(writedata[31:16]);
          end
          `REG_TP34:
          begin
            if (byteenable[1:0] == 2'h3)
              tp_reg[2] <= clamp_tp(writedata[15:0]);
            if (byteenable[3:2] == 2'h3)
              tp_reg[3] <= clamp_tp(writedata[31:16]);
          end
          default:
            ;                         // Unmapped writes ignored
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: src/sec_timer.v
/*
  One handshake timer: counts whole seconds on a shared tick and
  flags expiry when the configured limit is reached.
  Assumes tick is a one-cycle pulse from the same clock.
*/
`default_nettype none

module sec_timer #(
  parameter W = 10                    // Width of the seconds count
) (
  input  wire         ref_clk,        // System clock
  input  wire         nrst,           // Asynchronous reset, active low
  input  wire         restart,        // Start counting from zero
  input  wire         run,            // Counting allowed
  input  wire         tick,           // One-second pulse
  input  wire [W-1:0] limit,          // Seconds until expiry
  output reg          expired         // Limit reached, held while run
);

  reg [W-1:0] sec_reg;                // Elapsed seconds

  ////////////////////////////////////////////////////////////////////
  // Seconds counter; a restart wins over a tick in the same cycle
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sec_reg <= {W{1'b0}};
      expired <= 1'b0;
    end
    else if (restart || !run)
    begin
      sec_reg <= {W{1'b0}};
      expired <= 1'b0;
    end
    else if (tick && !expired)
    begin
      sec_reg <= sec_reg + {{(W-1){1'b0}}, 1'b1};
      expired <= (sec_reg + {{(W-1){1'b0}}, 1'b1}) >= limit;
    end
  end

endmodule

`default_nettype wire

// File: tb/handoff_chk.sv
/*
  Port checker for handoff_port: handshake order, stop, bus timing.
  Bound into every handoff_port; sees only its ports.
*/
`default_nettype none
module handoff_chk #(
  parameter TICK_LEN = 10
) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        cs_0,
  input wire logic        cs_1,
  input wire logic        valid,
  input wire logic        tr_req,
  input wire logic        busy,
  input wire logic        compt,
  input wire logic        ho_avbl,
  input wire logic        l_req,
  input wire logic        u_req,
  input wire logic        ready,
  input wire logic        es_n,
  input wire logic        placement,
  input wire logic        presence,
  input wire logic        estop_btn,
  input wire logic [4:0]  tp_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  // Inputs pass a two-stage sync, so causes are looked at two back
  a_req_after_sel: assert property ($rose(l_req) || $rose(u_req) |->
    $past(cs_0 && valid, 2)) else $error("request without select");
  a_one_req: assert property (!(l_req && u_req))
    else $error("both requests high");
  a_ready_after_tr: assert property ($rose(ready) |->
    $past(tr_req, 2) && $past(l_req || u_req)) else $error("early ready");
  a_ready_drop: assert property ($fell(ready) |->
    $past(compt, 2) || !es_n || (|tp_err)) else $error("ready dropped");
  a_lreq_drop: assert property ($fell(l_req) |->
    $past(placement && presence, 2) || !es_n || (|tp_err))
    else $error("load request dropped early");
  a_ureq_drop: assert property ($fell(u_req) |->
    $past(!placement && !presence, 2) || !es_n || (|tp_err))
    else $error("unload request dropped early");
  a_stop_quiet: assert property (!es_n && $past(!es_n) |->
    !(l_req || u_req || ready || ho_avbl)) else $error("outputs during stop");
  a_stop_resp: assert property ($rose(estop_btn) |-> ##[1:5] !es_n)
    else $error("stop output not low");
  a_stop_clear: assert property ($fell(estop_btn) |-> ##[1:5] es_n)
    else $error("stop output not restored");
  a_err_sticky: assert property ((|($past(tp_err) & ~tp_err)) |->
    $past(write) || $past(write, 2) || $past(write, 3))
    else $error("error flag lost");
  a_wait_one: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  c_load: cover property ($fell(l_req) && ready);
  c_unload: cover property ($fell(u_req) && ready);
  c_err: cover property (|tp_err);
  c_stop: cover property (!es_n);
endmodule

bind handoff_port handoff_chk #(.TICK_LEN(TICK_LEN)) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .cs_0(cs_0),
  .cs_1(cs_1), .valid(valid), .tr_req(tr_req), .busy(busy),
  .compt(compt), .ho_avbl(ho_avbl), .l_req(l_req), .u_req(u_req),
  .ready(ready), .es_n(es_n), .placement(placement),
  .presence(presence), .estop_btn(estop_btn), .tp_err(tp_err)
);
`default_nettype wire

// File: tb/handoff_port_tb.sv
/*
  Self-checking bench for handoff_port with a vehicle model.
  Assumes a second shortened to 10 cycles through TICK_LEN.
*/
`default_nettype none
module handoff_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 10;
  logic        ref_clk, nrst, read, write, waitrequest;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic        cs_0, cs_1, valid, tr_req, busy, compt, ho_avbl, l_req;
  logic        u_req, ready, es_n, placement, presence, estop_btn;
  logic [4:0]  tp_err;
  int          n_errors, n_tests, cyc;
  handoff_port #(.TICK_LEN(TL)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .cs_0(cs_0),
    .cs_1(cs_1), .valid(valid), .tr_req(tr_req), .busy(busy),
    .compt(compt), .ho_avbl(ho_avbl), .l_req(l_req), .u_req(u_req),
    .ready(ready), .es_n(es_n), .placement(placement),
    .presence(presence), .estop_btn(estop_btn), .tp_err(tp_err));
  veh_model i_veh (
    .ref_clk(ref_clk), .ho_avbl(ho_avbl), .l_req(l_req), .u_req(u_req),
    .ready(ready), .cs_0(cs_0), .cs_1(cs_1), .valid(valid),
    .tr_req(tr_req), .busy(busy), .compt(compt),
    .placement(placement), .presence(presence));
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard: a whole run needs under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Avalon accesses: held until waitrequest is sampled low
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  task t_regs;
    chk({ho_avbl, es_n, tp_err}, 7'h60);
    bus_rd(4'h8, rd);
    chk(rd, 32'h0002_0002);
    bus_rd(4'hc, rd);
    chk(rd, 32'h003c_003c);
    bus_rd(4'h0, rd);
    chk(rd, 32'h0002_0000);
    bus_rd(4'h2, rd);
    chk(rd, 32'h0000_0000);
    bus_wr(4'h8, 32'h03e8_0000);
    bus_rd(4'h8, rd);
    chk(rd, 32'h03e7_0001);
    bus_wr(4'h8, 32'h0002_0002);
    bus_wr(4'hc, 32'h0003_0003);
    bus_rd(4'hc, rd);
    chk(rd, 32'h0003_0003);
  endtask
  // Full load or unload
  task t_xfer(input logic ld);
    i_veh.put(!ld, !ld);
    i_veh.go(1, 1, ld, 1'b0, 1'b0);
    chk({l_req, u_req}, {ld, !ld});
    i_veh.go(2, 5, ld, ld, ld);
    repeat (5) @(posedge ref_clk);
    chk({ho_avbl, l_req, u_req, ready, tp_err}, 9'h100);
    i_veh.put(1'b0, 1'b0);
  endtask
  // Stall after stage e and expect timer n to fire and abort
  task t_tout(input int n, input int e, input logic ld, input logic plc,
              input logic prs);
    int i;
    i_veh.put(!ld, !ld);
    i_veh.go(1, e, ld, plc, prs);
    repeat (5) @(posedge ref_clk);
    chk(tp_err, 5'h00);
    if (n == 3)
      chk(ld ? l_req : u_req, 1'b1);
    i = 0;
    while (tp_err[n-1] !== 1'b1 && i < 200)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk(tp_err, 5'h01 << (n - 1));
    chk({l_req, u_req, ready}, 3'h0);
    i_veh.rel;
    i_veh.put(1'b0, 1'b0);
    bus_wr(4'h0, 32'h0002_0002);
    repeat (2) @(posedge ref_clk);
    chk(tp_err, 5'h00);
  endtask
  task t_estop;
    i_veh.put(1'b1, 1'b1);
    i_veh.go(1, 3, 1'b0, 1'b1, 1'b1);
    estop_btn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({es_n, u_req, ready, ho_avbl}, 4'h0);
    i_veh.rel;
    estop_btn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(es_n, 1'b1);
    chk(ho_avbl, 1'b1);
    i_veh.put(1'b0, 1'b0);
    bus_wr(4'h0, 32'h0002_0002);
  endtask
  task t_manual;
    bus_wr(4'h0, 32'h0002_0001);
    repeat (5) @(posedge ref_clk);
    chk(ho_avbl, 1'b0);
    bus_wr(4'h0, 32'h0002_0000);
    repeat (5) @(posedge ref_clk);
    chk(ho_avbl, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, read, write, estop_btn} = 4'h0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs;
    t_xfer(1'b1);
    t_xfer(1'b0);
    t_tout(1, 1, 1'b1, 1'b0, 1'b0);
    t_tout(2, 2, 1'b1, 1'b0, 1'b0);
    t_tout(3, 3, 1'b1, 1'b0, 1'b0);
    t_tout(4, 3, 1'b1, 1'b1, 1'b1);
    t_tout(5, 4, 1'b1, 1'b1, 1'b1);
    t_tout(3, 3, 1'b1, 1'b1, 1'b0);
    t_tout(3, 3, 1'b1, 1'b0, 1'b1);
    t_tout(3, 3, 1'b0, 1'b0, 1'b1);
    t_tout(3, 3, 1'b0, 1'b1, 1'b0);
    t_estop;
    t_manual;
    results;
  end
endmodule
`default_nettype wire

// File: tb/veh_model.sv
/*
  Active vehicle model: walks the handoff stage by stage.
  Assumes the bench timeout cuts any wait that never ends.
*/
`default_nettype none
module veh_model (
  input  wire logic ref_clk,
  input  wire logic ho_avbl,
  input  wire logic l_req,
  input  wire logic u_req,
  input  wire logic ready,
  output var  logic cs_0,
  output var  logic cs_1,
  output var  logic valid,
  output var  logic tr_req,
  output var  logic busy,
  output var  logic compt,
  output var  logic placement,
  output var  logic presence
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cs_0, cs_1, valid, tr_req, busy, compt, placement, presence} = 8'h00;
  ////////////////////////////////////////////////////////////////////
  // Carrier sensors as left by the vehicle
  task put(input logic plc, input logic prs);
    @(posedge ref_clk);
    placement <= plc;
    presence <= prs;
  endtask
  // Stages s0..s1; stage 3 waits for request drop only on a full move
  task go(input int s0, input int s1, input logic ld, input logic plc,
          input logic prs);
    for (int s = s0; s <= s1; s++)
    begin
      @(posedge ref_clk);
      case (s)
        1:
        begin
          while (ho_avbl !== 1'b1) @(posedge ref_clk);
          cs_0 <= 1'b1;
          cs_1 <= 1'b0;
          @(posedge ref_clk);
          valid <= 1'b1;
          do @(posedge ref_clk); while ((ld ? l_req : u_req) !== 1'b1);
        end
        2:
        begin
          tr_req <= 1'b1;
          do @(posedge ref_clk); while (ready !== 1'b1);
        end
        3:
        begin
          busy <= 1'b1;
          placement <= plc;
          presence <= prs;
          if (ld ? (plc && prs) : (!plc && !prs))
            do @(posedge ref_clk); while ((ld ? l_req : u_req) !== 1'b0);
        end
        4:
        begin
          {busy, tr_req, compt} <= 3'b001;
          do @(posedge ref_clk); while (ready !== 1'b0);
        end
        default: {compt, valid, cs_0} <= 3'b000;
      endcase
    end
  endtask
  // Release of every request line after a stop or an abort
  task rel;
    @(posedge ref_clk);
    {busy, tr_req, valid, cs_0, compt} <= 5'h00;
  endtask
endmodule
`default_nettype wire
